// file: src/ssr_receiver.sv
// Synchronous serial receiver: master or slave clocking, two-character FIFO,
// overrun handling, nine-bit characters, plain register port.
// Assumes data_line and clock_line arrive asynchronously from the link.
//
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps

// How it works
// - As master receiver the data line output driver stays off.
// - Reception starts when single or continuous receive enable is set.
// - Single receive: one character of clocks, then single enable self-clears.
// - Continuous receive: clocks keep running until continuous enable clears or an overrun is flagged.
// - Dropping the enable mid-character stops clock and discards partial character.
// - Both enables set: single clears after first character, continuous continues.
// - Data line sampled on each trailing clock edge into shift register.
// - Completed character sets receive flag and enters two-deep FIFO.
// - Data register read returns low eight bits of oldest character.
// - Receive flag stays set while the FIFO holds unread characters.
// - As slave the clock comes from the line; clock driver stays off.
// - Sender changes data on leading edge; one bit per clock cycle.
// - A third complete character with full FIFO sets the overrun flag.
// - On overrun FIFO contents are kept; no more characters accepted.
// - Overrun in single mode clears on a data register read.
// - Overrun in continuous mode clears by dropping continuous or port enable.
// - Nine-bit enable shifts nine bits per character instead of eight.
// - Ninth bit output shows bit eight of the oldest character.
// - Interrupt request raised while receive flag and its enable are set.
module ssr_receiver (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [ssr_pkg::ADDR_W-1:0] addr_i,
  input wire logic [ssr_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [ssr_pkg::DATA_W-1:0] rdata_o,
  input wire logic data_line_i,
  output logic data_line_o,
  output logic data_line_oe_o,
  input wire logic clock_line_i,
  output logic clock_line_o,
  output logic clock_line_oe_o,
  output logic receive_flag_o,
  output logic received_ninth_bit_o,
  output logic overrun_error_flag_o,
  output logic irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic data_s;
  logic clk_s;

  ssr_sync3 u_sync_data (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .async_i(data_line_i),
    .level_o(data_s)
  );

  ssr_sync3 u_sync_clk (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .async_i(clock_line_i),
    .level_o(clk_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State

  ssr_pkg::ssr_regs_t q, d;
  logic run;
  logic sample;
  logic char_done;
  logic data_rd;
  logic [3:0] nbits;
  logic [15:0] lim;
  logic [8:0] sh;
  logic [8:0] chr;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    d = q;
    d.rdata = '0;
    sample = 1'b0;
    char_done = 1'b0;
    sh = q.shreg;
    chr = ssr_pkg::CHAR_RST;
    data_rd = rd_i && (addr_i == ssr_pkg::OFS_DATA);

    // Register writes
    if (wr_i && addr_i == ssr_pkg::OFS_CTRL) begin
      d.serial_port_enable = wdata_i[ssr_pkg::B_SERIAL_PORT_ENABLE];
      d.sync = wdata_i[ssr_pkg::B_SYNC];
      d.master = wdata_i[ssr_pkg::B_MASTER];
      d.single_receive_enable = wdata_i[ssr_pkg::B_SINGLE_RECEIVE_ENABLE];
      d.continuous_receive_enable = wdata_i[ssr_pkg::B_CONTINUOUS_RECEIVE_ENABLE];
      d.nine = wdata_i[ssr_pkg::B_NINE];
      d.rie = wdata_i[ssr_pkg::B_RIE];
      d.high_baud_select = wdata_i[ssr_pkg::B_HIGH_BAUD_SELECT];
      d.wide = wdata_i[ssr_pkg::B_WIDE];
    end
    if (wr_i && addr_i == ssr_pkg::OFS_BAUD) begin
      d.baud = wdata_i[15:0];
    end

    // Register reads
    if (rd_i && addr_i == ssr_pkg::OFS_CTRL) begin
      d.rdata[ssr_pkg::B_SERIAL_PORT_ENABLE] = q.serial_port_enable;
      d.rdata[ssr_pkg::B_SYNC] = q.sync;
      d.rdata[ssr_pkg::B_MASTER] = q.master;
      d.rdata[ssr_pkg::B_SINGLE_RECEIVE_ENABLE] = q.single_receive_enable;
      d.rdata[ssr_pkg::B_CONTINUOUS_RECEIVE_ENABLE] = q.continuous_receive_enable;
      d.rdata[ssr_pkg::B_NINE] = q.nine;
      d.rdata[ssr_pkg::B_RIE] = q.rie;
      d.rdata[ssr_pkg::B_HIGH_BAUD_SELECT] = q.high_baud_select;
      d.rdata[ssr_pkg::B_WIDE] = q.wide;
      d.rdata[ssr_pkg::B_OVR] = q.ovr;
      d.rdata[ssr_pkg::B_NINTH] = q.fifo[0][8];
      d.rdata[ssr_pkg::B_FLAG] = (q.count != 2'h0);
    end
    if (rd_i && addr_i == ssr_pkg::OFS_BAUD) begin
      d.rdata[15:0] = q.baud;
    end
    if (data_rd) begin
      d.rdata[7:0] = q.fifo[0][7:0];
      if (q.count != 2'h0) begin
        d.fifo[0] = q.fifo[1];
        d.fifo[1] = ssr_pkg::CHAR_RST;
        d.count = q.count - 2'h1;
      end
      if (q.ovr && !q.ovr_cont) begin
        d.ovr = 1'b0;
      end
    end
    if (q.ovr && q.ovr_cont && !d.continuous_receive_enable) begin
      d.ovr = 1'b0;
    end

    // Link side
    nbits = d.nine ? ssr_pkg::BITS_LONG : ssr_pkg::BITS_SHORT;
    lim = q.wide ? q.baud : {8'h00, q.baud[7:0]};
    run = d.serial_port_enable && d.sync && (d.single_receive_enable || d.continuous_receive_enable) && !d.ovr;
    d.slv_prev = clk_s;

    if (!run) begin
      // Partial character dropped, clock parked low
      d.state = ssr_pkg::SSR_IDLE;
      d.clk_out = 1'b0;
      d.div = '0;
      d.bitcnt = '0;
    end else if (q.master) begin
      unique case (q.state)
        ssr_pkg::SSR_IDLE: begin
          d.state = ssr_pkg::SSR_SHIFT;
          d.div = '0;
          d.clk_out = 1'b0;
        end
        ssr_pkg::SSR_SHIFT: begin
          if (q.div >= lim) begin
            d.div = '0;
            d.clk_out = !q.clk_out;
            sample = q.clk_out;
          end else begin
            d.div = q.div + 16'h0001;
          end
        end
      endcase
    end else begin
      d.state = ssr_pkg::SSR_IDLE;
      d.clk_out = 1'b0;
      sample = q.slv_prev && !clk_s;
    end

    if (sample) begin
      sh[q.bitcnt] = data_s;
      d.shreg = sh;
      if (q.bitcnt >= nbits - 4'h1) begin
        char_done = 1'b1;
        d.bitcnt = '0;
        chr = d.nine ? sh : {1'b0, sh[7:0]};
      end else begin
        d.bitcnt = q.bitcnt + 4'h1;
      end
    end

    if (char_done) begin
      if (d.count == ssr_pkg::FIFO_DEPTH) begin
        d.ovr = 1'b1;
        d.ovr_cont = d.continuous_receive_enable;
      end else begin
        d.fifo[d.count[0]] = chr;
        d.count = d.count + 2'h1;
      end
      if (d.single_receive_enable) begin
        d.single_receive_enable = 1'b0;
      end
      if (!d.continuous_receive_enable) begin
        d.state = ssr_pkg::SSR_IDLE;
        d.clk_out = 1'b0;
        d.div = '0;
      end
    end

    // Port enable clear resets the receive path
    if (!d.serial_port_enable) begin
      d.count = '0;
      d.fifo = '0;
      d.ovr = 1'b0;
      d.ovr_cont = 1'b0;
      d.bitcnt = '0;
      d.shreg = '0;
      d.state = ssr_pkg::SSR_IDLE;
      d.clk_out = 1'b0;
      d.div = '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      q <= '0;
      q.baud <= ssr_pkg::BAUD_RST;
      q.state <= ssr_pkg::SSR_IDLE;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign rdata_o = q.rdata;
  assign data_line_o = 1'b0;
  assign data_line_oe_o = 1'b0;
  assign clock_line_o = q.clk_out;
  assign clock_line_oe_o = q.serial_port_enable && q.sync && q.master;
  assign receive_flag_o = (q.count != 2'h0);
  assign received_ninth_bit_o = q.fifo[0][8];
  assign overrun_error_flag_o = q.ovr;
  assign irq_o = receive_flag_o && q.rie;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  data_drv_off_a: assert property (q.master |-> !data_line_oe_o)
    else $error("data line driven in master receive");

  slave_clk_off_a: assert property (!q.master |=> (!q.master && !wr_i) |-> !clock_line_oe_o)
    else $error("clock line driven as slave");

  single_clear_a: assert property (char_done && q.single_receive_enable && !wr_i |=> !q.single_receive_enable)
    else $error("single enable not cleared after character");

  overrun_set_a: assert property (char_done && q.count == 2'h2 && !data_rd && d.serial_port_enable |=> q.ovr)
    else $error("overrun flag not set on third character");

  overrun_hold_a: assert property (q.ovr && !data_rd && !wr_i |=> $stable(q.fifo))
    else $error("FIFO changed during overrun");

  read_data_a: assert property (data_rd |=> rdata_o[7:0] == $past(q.fifo[0][7:0]))
    else $error("data read returned wrong character");

  pop_flag_a: assert property (data_rd && q.count == 2'h1 && !char_done |=> !receive_flag_o)
    else $error("flag stayed set with empty FIFO");

  stop_clk_a: assert property (q.master && !q.single_receive_enable && !q.continuous_receive_enable && !wr_i |=> !clock_line_o)
    else $error("clock kept running without enable");

  irq_gate_a: assert property (receive_flag_o && q.rie |-> irq_o)
    else $error("interrupt request missing");

  single_char_c: cover property (char_done && q.single_receive_enable && !q.continuous_receive_enable);
  overrun_c: cover property (char_done && q.count == 2'h2);
  nine_bit_c: cover property (char_done && q.nine && !q.master);

endmodule // ssr_receiver

// file: src/ssr_pkg.sv
// Constants, register map and state carrier of the synchronous serial receiver.
// Assumes a 50 MHz system clock and a plain one-cycle register port.
package ssr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register port
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_BAUD = 8'h04;
  localparam logic [7:0] OFS_DATA = 8'h08;

  ////////////////////////////////////////////////////////////////////////////
  // Control word field positions
  localparam int unsigned B_SERIAL_PORT_ENABLE = 0;
  localparam int unsigned B_SYNC = 1;
  localparam int unsigned B_MASTER = 2;
  localparam int unsigned B_SINGLE_RECEIVE_ENABLE = 3;
  localparam int unsigned B_CONTINUOUS_RECEIVE_ENABLE = 4;
  localparam int unsigned B_NINE = 5;
  localparam int unsigned B_RIE = 6;
  localparam int unsigned B_HIGH_BAUD_SELECT = 7;
  localparam int unsigned B_WIDE = 8;
  localparam int unsigned B_OVR = 9;
  localparam int unsigned B_NINTH = 10;
  localparam int unsigned B_FLAG = 11;

  ////////////////////////////////////////////////////////////////////////////
  // Character and buffer figures, reset values
  localparam logic [3:0] BITS_SHORT = 4'h8;
  localparam logic [3:0] BITS_LONG = 4'h9;
  localparam logic [1:0] FIFO_DEPTH = 2'h2;
  localparam logic [15:0] BAUD_RST = 16'h0000;
  localparam logic [8:0] CHAR_RST = 9'h000;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {
    SSR_IDLE = 2'b01,
    SSR_SHIFT = 2'b10
  } ssr_state_t;

  typedef struct packed {
    logic serial_port_enable;
    logic sync;
    logic master;
    logic single_receive_enable;
    logic continuous_receive_enable;
    logic nine;
    logic rie;
    logic high_baud_select;
    logic wide;
    logic [15:0] baud;
    logic [1:0][8:0] fifo;
    logic [1:0] count;
    logic [8:0] shreg;
    logic [3:0] bitcnt;
    logic clk_out;
    logic [15:0] div;
    logic ovr;
    logic ovr_cont;
    logic slv_prev;
    logic [31:0] rdata;
    ssr_state_t state;
  } ssr_regs_t;

  typedef struct packed {
    logic ff1;
    logic ff2;
    logic ff3;
    logic level;
  } ssr_sync_t;

endpackage

// file: src/ssr_sync3.sv
// Three-stage input synchroniser with agreement filter.
// Assumes the input is asynchronous to clk_i.
`timescale 1ns/100ps

module ssr_sync3 (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic async_i,
  output logic level_o
);

  ssr_pkg::ssr_sync_t q, d;

  always_comb begin
    d = q;
    d.ff1 = async_i;
    d.ff2 = q.ff1;
    d.ff3 = q.ff2;
    // Change accepted only when stages two and three agree
    if (q.ff2 == q.ff3) begin
      d.level = q.ff3;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign level_o = q.level;

endmodule // ssr_sync3

// file: dv/ssr_partner.sv
// Far-side serial device: shifts characters out on the data line, LSB first.
// Assumes the clock line it sees is the wired level of both clock drivers.
`timescale 1ns/100ps

module ssr_partner (
  input wire logic clk_i,
  input wire logic sck_i,
  input wire logic nine_i,
  output logic data_o,
  output logic sck_o
);
  logic [8:0] q[$];
  logic [8:0] cur;
  int idx;

  initial begin
    data_o = 1'b0;
    sck_o = 1'b0;
    cur = 9'h000;
    idx = 0;
  end

  task automatic push(input logic [8:0] ch);
    q.push_back(ch);
  endtask

  task automatic flush();
    q.delete();
    idx = 0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Data moves on the leading edge, one bit per clock
  always @(posedge sck_i) begin
    if (idx == 0) cur = (q.size() != 0) ? q.pop_front() : ~cur;
    data_o = cur[idx];
    idx = (idx == (nine_i ? 8 : 7)) ? 0 : idx + 1;
  end

  // Hold expired: line shows the inverse of the last bit
  always @(negedge sck_i) begin
    if (idx == 0) begin
      repeat (6) @(posedge clk_i);
      if (idx == 0 && !sck_i) data_o = ~data_o;
    end
  end

  // External master: exactly n clocks, 160 ns each
  task automatic send(input int n);
    repeat (n) begin
      #80 sck_o = 1'b1;
      #80 sck_o = 1'b0;
    end
  endtask
endmodule // ssr_partner

// file: dv/testbench.sv
// Self-checking bench of the synchronous serial receiver.
// Assumes the partner model on the link and register access through the plain port.
`timescale 1ns/100ps

module testbench;
  logic clk_i, rst_n_i, wr_i, rd_i, rd_d, cl_prev, nine, rie;
  logic [ssr_pkg::ADDR_W-1:0] addr_i;
  logic [ssr_pkg::DATA_W-1:0] wdata_i, rdata_o, base;
  logic data_line_o, data_line_oe_o, clock_line_o, clock_line_oe_o;
  logic receive_flag_o, received_ninth_bit_o, overrun_error_flag_o, irq_o;
  logic p_data, p_sck, data_line_w, clock_line_w;
  logic [31:0] exp_q[$], msk_q[$];
  logic [8:0] ch[3];
  int miscompares, comparisons, rises, seed;

`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin miscompares++; \
  $display("BAD %0t mismatch %h vs %h", $time, a, b); end end

  assign data_line_w = data_line_oe_o ? data_line_o : p_data;
  assign clock_line_w = clock_line_oe_o ? clock_line_o : p_sck;

  ssr_receiver DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .data_line_i(data_line_w),
    .data_line_o(data_line_o), .data_line_oe_o(data_line_oe_o), .clock_line_i(clock_line_w),
    .clock_line_o(clock_line_o), .clock_line_oe_o(clock_line_oe_o),
    .receive_flag_o(receive_flag_o), .received_ninth_bit_o(received_ninth_bit_o),
    .overrun_error_flag_o(overrun_error_flag_o), .irq_o(irq_o));

  ssr_partner partner (.clk_i(clk_i), .sck_i(clock_line_w), .nine_i(nine),
    .data_o(p_data), .sck_o(p_sck));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus tasks and helpers
  function automatic logic [31:0] bt(input int b);
    return 32'h0000_0001 << b;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wait_rises(input int n, input int tail);
    int k;
    k = 0;
    while (rises < n && k < 3000) begin
      @(posedge clk_i);
      k++;
    end
    if (k >= 3000) miscompares++;
    repeat (tail) @(posedge clk_i);
  endtask

  task automatic close_out();
    $display("miscompares %0d comparisons %0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Output watcher: read data against the oldest note
  always @(posedge clk_i) rd_d <= rd_i;
  always @(negedge clk_i) begin
    cl_prev <= clock_line_o;
    if (clock_line_o === 1'b1 && cl_prev === 1'b0) rises++;
    if (rst_n_i) begin
      `CHK(data_line_oe_o, 1'b0)
      `CHK(irq_o, receive_flag_o & rie)
    end
    if (rd_d) begin
      `CHK(rdata_o & msk_q[0], exp_q[0])
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  end

  initial begin
    #1_000_000;
    miscompares++;
    close_out();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tests
  initial begin
    {wr_i, rd_i, rd_d, cl_prev, nine, rie, rst_n_i} = 7'h00;
    addr_i = 8'h00;
    wdata_i = 32'h0000_0000;
    seed = 69;
    for (int i = 0; i < 3; i++) ch[i] = 9'($random(seed));
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    rd(ssr_pkg::OFS_CTRL, 32'h0000_0000, 32'hFFFF_FFFF);
    rd(ssr_pkg::OFS_BAUD, 32'h0000_0000, 32'hFFFF_FFFF);
    rd(8'h0C, 32'h0000_0000, 32'hFFFF_FFFF);
    $display("test reset done");
    wr(ssr_pkg::OFS_BAUD, 32'h0000_0007);
    base = bt(ssr_pkg::B_SERIAL_PORT_ENABLE) | bt(ssr_pkg::B_SYNC) | bt(ssr_pkg::B_MASTER);
    base = base | bt(ssr_pkg::B_RIE);
    wr(ssr_pkg::OFS_CTRL, base);
    rie = 1'b1;
    partner.push(ch[0]);
    rises = 0;
    wr(ssr_pkg::OFS_CTRL, base | bt(ssr_pkg::B_SINGLE_RECEIVE_ENABLE));
    wait_rises(8, 60);
    `CHK(rises, 8)
    `CHK(receive_flag_o, 1'b1)
    rd(ssr_pkg::OFS_CTRL, bt(ssr_pkg::B_FLAG), bt(ssr_pkg::B_SINGLE_RECEIVE_ENABLE) | bt(ssr_pkg::B_FLAG));
    rd(ssr_pkg::OFS_DATA, {24'h00_0000, ch[0][7:0]}, 32'h0000_00FF);
    `CHK(receive_flag_o, 1'b0)
    $display("test single done");
    nine = 1'b1;
    for (int i = 0; i < 3; i++) begin
      partner.push(ch[i]);
      rises = 0;
      wr(ssr_pkg::OFS_CTRL, base | bt(ssr_pkg::B_NINE) | bt(ssr_pkg::B_SINGLE_RECEIVE_ENABLE));
      wait_rises(9, 60);
      `CHK(rises, 9)
    end
    `CHK(overrun_error_flag_o, 1'b1)
    for (int i = 0; i < 2; i++) begin
      `CHK(received_ninth_bit_o, ch[i][8])
      rd(ssr_pkg::OFS_CTRL, ch[i][8] ? bt(ssr_pkg::B_NINTH) : 32'h0000_0000,
        bt(ssr_pkg::B_NINTH));
      rd(ssr_pkg::OFS_DATA, {24'h00_0000, ch[i][7:0]}, 32'h0000_00FF);
      `CHK(overrun_error_flag_o, 1'b0)
    end
    `CHK(receive_flag_o, 1'b0)
    $display("test overrun single done");
    nine = 1'b0;
    for (int i = 0; i < 3; i++) partner.push(ch[i]);
    rises = 0;
    wr(ssr_pkg::OFS_CTRL, base | bt(ssr_pkg::B_CONTINUOUS_RECEIVE_ENABLE));
    wait_rises(24, 80);
    `CHK(rises, 24)
    `CHK(overrun_error_flag_o, 1'b1)
    wr(ssr_pkg::OFS_CTRL, base);
    `CHK(overrun_error_flag_o, 1'b0)
    rd(ssr_pkg::OFS_DATA, {24'h00_0000, ch[0][7:0]}, 32'h0000_00FF);
    rd(ssr_pkg::OFS_DATA, {24'h00_0000, ch[1][7:0]}, 32'h0000_00FF);
    $display("test continuous done");
    partner.flush();
    partner.push(ch[2]);
    rises = 0;
    wr(ssr_pkg::OFS_CTRL, base | bt(ssr_pkg::B_CONTINUOUS_RECEIVE_ENABLE) | bt(ssr_pkg::B_SINGLE_RECEIVE_ENABLE));
    wait_rises(11, 0);
    rd(ssr_pkg::OFS_CTRL, bt(ssr_pkg::B_CONTINUOUS_RECEIVE_ENABLE) | bt(ssr_pkg::B_FLAG),
      bt(ssr_pkg::B_SINGLE_RECEIVE_ENABLE) | bt(ssr_pkg::B_CONTINUOUS_RECEIVE_ENABLE) | bt(ssr_pkg::B_FLAG));
    wr(ssr_pkg::OFS_CTRL, base);
    `CHK(clock_line_o, 1'b0)
    repeat (60) @(posedge clk_i);
    `CHK(rises, 11)
    `CHK(receive_flag_o, 1'b1)
    rd(ssr_pkg::OFS_DATA, {24'h00_0000, ch[2][7:0]}, 32'h0000_00FF);
    @(posedge clk_i);
    `CHK(receive_flag_o, 1'b0)
    partner.flush();
    $display("test abort done");
    wr(ssr_pkg::OFS_CTRL, bt(ssr_pkg::B_SERIAL_PORT_ENABLE) | bt(ssr_pkg::B_SYNC) | bt(ssr_pkg::B_CONTINUOUS_RECEIVE_ENABLE));
    rie = 1'b0;
    `CHK(clock_line_oe_o, 1'b0)
    partner.push(ch[1]);
    partner.send(8);
    repeat (20) @(posedge clk_i);
    `CHK(receive_flag_o, 1'b1)
    rd(ssr_pkg::OFS_DATA, {24'h00_0000, ch[1][7:0]}, 32'h0000_00FF);
    $display("test slave done");
    close_out();
  end
endmodule // testbench
